/* File: dsp_consts.svh */
// Constants of the serial port with modem control: rates, timing, host register map.
// Assumes a 40 MHz clock; included by both ends and never compiled on its own.
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH
`define DSP_CLK_HZ 40000000
`define DSP_MS_CYCLES (`DSP_CLK_HZ / 1000)
`define DSP_DATA_BITS 8
`define DSP_STOP_BITS 1
`define DSP_RATE_MIN_BPS 1200
`define DSP_RATE_MAX_BPS 921600
`define DSP_AB_MIN_BPS 1200
`define DSP_AB_MAX_BPS 230400
// Shortest bit time rounds up, longest rounds down
`define DSP_DIV_MIN ((`DSP_CLK_HZ + `DSP_RATE_MAX_BPS - 1) / `DSP_RATE_MAX_BPS)
`define DSP_DIV_MAX (`DSP_CLK_HZ / `DSP_RATE_MIN_BPS)
`define DSP_AB_DIV_MIN ((`DSP_CLK_HZ + `DSP_AB_MAX_BPS - 1) / `DSP_AB_MAX_BPS)
`define DSP_AB_DIV_MAX (`DSP_CLK_HZ / `DSP_AB_MIN_BPS)
`define DSP_DIV_RESET 16'h015b
`define DSP_XON 8'h11
`define DSP_XOFF 8'h13
`define DSP_DTR_POLL_MS 1000
`define DSP_URC_PULSE_MS 1
// Host register offsets
`define DSP_REG_CTRL 8'h00
`define DSP_REG_STATUS 8'h04
`define DSP_REG_TXDATA 8'h08
`define DSP_REG_RXDATA 8'h0c
`define DSP_REG_DIV 8'h10
`define DSP_REG_INT_STAT 8'h14
`define DSP_REG_INT_MASK 8'h18
// Control bits
`define DSP_CTRL_HW_FLOW 0
`define DSP_CTRL_SW_FLOW 1
`define DSP_CTRL_TERM_READY 2
`define DSP_CTRL_SEND_REQ 3
// Status bits
`define DSP_ST_TX_BUSY 0
`define DSP_ST_RX_FULL 1
`define DSP_ST_CLEAR 2
`define DSP_ST_CARRIER 3
`define DSP_ST_RING 4
`define DSP_ST_SET_READY 5
// Interrupt bits
`define DSP_INT_RX 0
`define DSP_INT_TX 1
`define DSP_INT_RING 2
`define DSP_INT_CARRIER 3
`endif

/* File: dsp_pkg.sv */
// Types shared by both ends of the serial link.
// Assumes nothing of its surroundings.
package dsp_pkg;
  typedef enum logic [2:0] {
    DSP_RX_IDLE = 3'b000,
    DSP_RX_START = 3'b001,
    DSP_RX_DATA = 3'b010,
    DSP_RX_STOP = 3'b011,
    DSP_RX_BAUD = 3'b100
  } dsp_rx_t;
  typedef enum logic {
    DSP_TX_IDLE = 1'b0,
    DSP_TX_SEND = 1'b1
  } dsp_tx_t;
  typedef enum logic [1:0] {
    DSP_RING_OFF = 2'b00,
    DSP_RING_CALL = 2'b01,
    DSP_RING_CALL_URC = 2'b10
  } dsp_ring_mode_t;
  typedef enum logic [1:0] {
    DSP_ALT_SET_READY = 2'b00,
    DSP_ALT_GPIO = 2'b01,
    DSP_ALT_SPI_CLK = 2'b10
  } dsp_alt_func_t;
endpackage : dsp_pkg

/* File: dsp_link_if.sv */
// Serial link between the equipment end and the terminal end.
// Assumes both ends share no clock; all levels high mean asserted, line idle is high.
`timescale 1ns/1ps
interface dsp_link_if;
  logic serial_in_from_host;
  logic terminal_ready_in;
  logic send_request_in;
  logic serial_out_to_host;
  logic carrier_detect_out;
  logic set_ready_out;
  logic send_clear_out;
  logic ring_indicate_out;
  modport dce (
    input serial_in_from_host, terminal_ready_in, send_request_in,
    output serial_out_to_host, carrier_detect_out, set_ready_out, send_clear_out, ring_indicate_out
  );
  modport dte (
    output serial_in_from_host, terminal_ready_in, send_request_in,
    input serial_out_to_host, carrier_detect_out, set_ready_out, send_clear_out, ring_indicate_out
  );
endinterface : dsp_link_if

/* File: dsp_dce.sv */
// Equipment end of the serial port: 8N1 receiver and transmitter, rate detection, flow control,
// modem control lines and the alternate set-ready pin.
// Assumes a 40 MHz clk, synchronous active-low reset, and link pins that are asynchronous to clk.
// Functional notes
// - Characters are 8 data bits, no parity, 1 stop
// - Fixed bit rate from 1200 to 921k
// - Rate detection accepts only 1.2k to 230k
// - Send request and send clear gate transfers
// - XON/XOFF pause and resume transmission
// - Equipment role: listed outputs and inputs
// - Host drives commands onto serial input line
// - Device answers on its serial output line
// - Ring output signals call or unsolicited result
// - Terminal ready sampled once per second only
// - Alternate set-ready pin has one function; here cfg_alt_func selects set ready, GPIO or SPI clock
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "dsp_consts.svh"
module dsp_dce
  import dsp_pkg::*;
#(
  parameter int unsigned DTR_POLL_CYCLES = `DSP_DTR_POLL_MS * `DSP_MS_CYCLES,
  parameter int unsigned URC_PULSE_CYCLES = `DSP_URC_PULSE_MS * `DSP_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  dsp_link_if.dce lnk,
  // Configuration
  input wire logic [15:0] cfg_rate_div,
  input wire logic cfg_autobaud,
  input wire logic cfg_hw_flow,
  input wire logic cfg_sw_flow,
  input wire dsp_ring_mode_t cfg_ring_mode,
  input wire dsp_alt_func_t cfg_alt_func,
  // Transmit data
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Receive data
  input wire logic rx_room,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_frame_err,
  output logic rate_locked,
  // Modem control
  input wire logic carrier_on,
  input wire logic set_ready,
  input wire logic call_ring,
  input wire logic urc_event,
  input wire logic gpio_out,
  input wire logic spi_clk_in,
  output logic alt_pin_out,
  output logic terminal_ready,
  output logic ignite
);
  logic [2:0] sync0;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] pin_q;
  logic [2:0] next_pin_q;
  // Pin synchroniser; bit 0 serial data, bit 1 send request, bit 2 terminal ready
  always_ff @(posedge clk) begin
    sync0 <= {lnk.terminal_ready_in, lnk.send_request_in, lnk.serial_in_from_host};
    sync1 <= sync0;
    sync2 <= sync1;
    pin_q <= next_pin_q;
  end
  always_comb begin
    next_pin_q = pin_q;
    for (int i = 0; i < 3; i++) begin
      if (sync1[i] == sync2[i]) begin
        next_pin_q[i] = sync2[i];
      end
    end
    if (!resetn) begin
      next_pin_q = 3'h1;
    end
  end

  logic [15:0] fix_div;
  logic [15:0] bit_div;
  logic [15:0] ab_div;
  logic ab_locked;
  always_comb begin
    fix_div = cfg_rate_div;
    if (cfg_rate_div < 16'(`DSP_DIV_MIN)) begin
      fix_div = 16'(`DSP_DIV_MIN);
    end else if (cfg_rate_div > 16'(`DSP_DIV_MAX)) begin
      fix_div = 16'(`DSP_DIV_MAX);
    end
    bit_div = (cfg_autobaud && ab_locked) ? ab_div : fix_div;
  end

  // Receiver
  dsp_rx_t rx_st, next_rx_st;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  logic [7:0] next_rx_data;
  logic next_rx_valid, next_rx_frame_err;
  logic [15:0] next_ab_div;
  logic next_ab_locked;
  logic paused, next_paused;
  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt + 16'h0001;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    next_rx_frame_err = 1'b0;
    next_ab_div = ab_div;
    next_ab_locked = ab_locked && cfg_autobaud;
    next_paused = paused && cfg_sw_flow;
    case (rx_st)
      DSP_RX_IDLE: begin
        next_rx_cnt = 16'h0000;
        next_rx_bit = 3'h0;
        if (!pin_q[0]) begin
          next_rx_st = (cfg_autobaud && !ab_locked) ? DSP_RX_BAUD : DSP_RX_START;
        end
      end
      DSP_RX_BAUD: begin
        // Start bit width is the bit time; the rest of the character is still received
        if (rx_cnt > 16'(`DSP_AB_DIV_MAX)) begin
          next_rx_st = DSP_RX_IDLE;
        end else if (pin_q[0]) begin
          if (rx_cnt >= 16'(`DSP_AB_DIV_MIN)) begin
            next_ab_div = rx_cnt;
            next_ab_locked = 1'b1;
            next_rx_st = DSP_RX_DATA;
            next_rx_cnt = {1'b0, rx_cnt[15:1]};
          end else begin
            next_rx_st = DSP_RX_IDLE;
          end
        end
      end
      DSP_RX_START: begin
        if (rx_cnt == {1'b0, bit_div[15:1]}) begin
          next_rx_cnt = 16'h0000;
          next_rx_st = pin_q[0] ? DSP_RX_IDLE : DSP_RX_DATA;
        end
      end
      DSP_RX_DATA: begin
        if (rx_cnt == bit_div - 16'h0001) begin
          next_rx_cnt = 16'h0000;
          next_rx_sh = {pin_q[0], rx_sh[7:1]};
          next_rx_bit = rx_bit + 3'h1;
          if (rx_bit == 3'h7) begin
            next_rx_st = DSP_RX_STOP;
          end
        end
      end
      DSP_RX_STOP: begin
        if (rx_cnt == bit_div - 16'h0001) begin
          next_rx_st = DSP_RX_IDLE;
          if (!pin_q[0]) begin
            next_rx_frame_err = 1'b1;
          end else if (cfg_sw_flow && rx_sh == `DSP_XOFF) begin
            next_paused = 1'b1;
          end else if (cfg_sw_flow && rx_sh == `DSP_XON) begin
            next_paused = 1'b0;
          end else begin
            next_rx_valid = 1'b1;
            next_rx_data = rx_sh;
          end
        end
      end
      default: begin
        next_rx_st = DSP_RX_IDLE;
      end
    endcase
    if (!resetn) begin
      next_rx_st = DSP_RX_IDLE;
      next_rx_cnt = 16'h0000;
      next_rx_bit = 3'h0;
      next_rx_sh = 8'h00;
      next_rx_data = 8'h00;
      next_rx_valid = 1'b0;
      next_rx_frame_err = 1'b0;
      next_ab_div = `DSP_DIV_RESET;
      next_ab_locked = 1'b0;
      next_paused = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    rx_st <= next_rx_st;
    rx_cnt <= next_rx_cnt;
    rx_bit <= next_rx_bit;
    rx_sh <= next_rx_sh;
    rx_data <= next_rx_data;
    rx_valid <= next_rx_valid;
    rx_frame_err <= next_rx_frame_err;
    ab_div <= next_ab_div;
    ab_locked <= next_ab_locked;
    rate_locked <= next_ab_locked;
    paused <= next_paused;
  end

  // Transmitter; permission is checked only between characters, never inside one
  dsp_tx_t tx_st, next_tx_st;
  logic [9:0] tx_sh, next_tx_sh;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_bit, next_tx_bit;
  logic tx_line, next_tx_line;
  logic next_tx_ready;
  logic permit;
  always_comb begin
    permit = (!cfg_hw_flow || pin_q[1]) && (!cfg_sw_flow || !paused);
    next_tx_st = tx_st;
    next_tx_sh = tx_sh;
    next_tx_cnt = tx_cnt + 16'h0001;
    next_tx_bit = tx_bit;
    case (tx_st)
      DSP_TX_IDLE: begin
        next_tx_cnt = 16'h0000;
        next_tx_bit = 4'h0;
        if (tx_valid && tx_ready) begin
          next_tx_sh = {1'b1, tx_data, 1'b0};
          next_tx_st = DSP_TX_SEND;
        end
      end
      DSP_TX_SEND: begin
        if (tx_cnt == bit_div - 16'h0001) begin
          next_tx_cnt = 16'h0000;
          next_tx_sh = {1'b1, tx_sh[9:1]};
          next_tx_bit = tx_bit + 4'h1;
          if (tx_bit == 4'h9) begin
            next_tx_st = DSP_TX_IDLE;
          end
        end
      end
      default: begin
        next_tx_st = DSP_TX_IDLE;
      end
    endcase
    if (!resetn) begin
      next_tx_st = DSP_TX_IDLE;
      next_tx_sh = 10'h3ff;
      next_tx_cnt = 16'h0000;
      next_tx_bit = 4'h0;
    end
    next_tx_line = (next_tx_st == DSP_TX_SEND) ? next_tx_sh[0] : 1'b1;
    next_tx_ready = resetn && (next_tx_st == DSP_TX_IDLE) && permit;
  end
  always_ff @(posedge clk) begin
    tx_st <= next_tx_st;
    tx_sh <= next_tx_sh;
    tx_cnt <= next_tx_cnt;
    tx_bit <= next_tx_bit;
    tx_line <= next_tx_line;
    tx_ready <= next_tx_ready;
  end

  // Modem control
  logic [25:0] poll_cnt, next_poll_cnt;
  logic dtr_primed, next_dtr_primed;
  logic next_terminal_ready, next_ignite;
  logic [15:0] urc_cnt, next_urc_cnt;
  logic ring, next_ring;
  logic clear, next_clear;
  logic carrier, next_carrier;
  logic dsr, next_dsr;
  logic next_alt_pin_out;
  always_comb begin
    next_poll_cnt = poll_cnt + 26'h1;
    next_dtr_primed = dtr_primed;
    next_terminal_ready = terminal_ready;
    next_ignite = 1'b0;
    if (poll_cnt == 26'(DTR_POLL_CYCLES - 1)) begin
      next_poll_cnt = 26'h0;
      next_terminal_ready = pin_q[2];
      next_dtr_primed = 1'b1;
      next_ignite = dtr_primed && pin_q[2] && !terminal_ready;
    end
    next_urc_cnt = (urc_cnt != 16'h0000) ? urc_cnt - 16'h0001 : 16'h0000;
    if (cfg_ring_mode == DSP_RING_CALL_URC && urc_event) begin
      next_urc_cnt = 16'(URC_PULSE_CYCLES);
    end
    case (cfg_ring_mode)
      DSP_RING_CALL: next_ring = call_ring;
      DSP_RING_CALL_URC: next_ring = call_ring || (next_urc_cnt != 16'h0000);
      default: next_ring = 1'b0;
    endcase
    next_clear = !cfg_hw_flow || rx_room;
    next_carrier = carrier_on;
    next_dsr = (cfg_alt_func == DSP_ALT_SET_READY) && set_ready;
    case (cfg_alt_func)
      DSP_ALT_SET_READY: next_alt_pin_out = set_ready;
      DSP_ALT_GPIO: next_alt_pin_out = gpio_out;
      DSP_ALT_SPI_CLK: next_alt_pin_out = spi_clk_in;
      default: next_alt_pin_out = 1'b0;
    endcase
    if (!resetn) begin
      next_poll_cnt = 26'h0;
      next_dtr_primed = 1'b0;
      next_terminal_ready = 1'b0;
      next_ignite = 1'b0;
      next_urc_cnt = 16'h0000;
      next_ring = 1'b0;
      next_clear = 1'b0;
      next_carrier = 1'b0;
      next_dsr = 1'b0;
      next_alt_pin_out = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    poll_cnt <= next_poll_cnt;
    dtr_primed <= next_dtr_primed;
    terminal_ready <= next_terminal_ready;
    ignite <= next_ignite;
    urc_cnt <= next_urc_cnt;
    ring <= next_ring;
    clear <= next_clear;
    carrier <= next_carrier;
    dsr <= next_dsr;
    alt_pin_out <= next_alt_pin_out;
  end

  assign lnk.serial_out_to_host = tx_line;
  assign lnk.send_clear_out = clear;
  assign lnk.carrier_detect_out = carrier;
  assign lnk.set_ready_out = dsr;
  assign lnk.ring_indicate_out = ring;
endmodule : dsp_dce

/* File: dsp_dte.sv */
// Terminal end of the serial link: an APB-controlled 8N1 port with flow control and modem lines.
// Assumes a 40 MHz clk, synchronous active-low reset, and link inputs asynchronous to clk.
`timescale 1ns/1ps
`include "dsp_consts.svh"
module dsp_dte
  import dsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Link
  dsp_link_if.dte lnk
);
  logic [4:0] sync0;
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] pin_q;
  logic [4:0] next_pin_q;
  // Bit 0 data, 1 send clear, 2 carrier, 3 ring, 4 set ready
  always_ff @(posedge clk) begin
    sync0 <= {lnk.set_ready_out, lnk.ring_indicate_out, lnk.carrier_detect_out, lnk.send_clear_out,
              lnk.serial_out_to_host};
    sync1 <= sync0;
    sync2 <= sync1;
    pin_q <= next_pin_q;
  end
  always_comb begin
    next_pin_q = pin_q;
    for (int i = 0; i < 5; i++) begin
      if (sync1[i] == sync2[i]) begin
        next_pin_q[i] = sync2[i];
      end
    end
    if (!resetn) begin
      next_pin_q = 5'h01;
    end
  end

  logic [3:0] ctrl, next_ctrl;
  logic [15:0] div, next_div;
  logic [3:0] int_stat, next_int_stat;
  logic [3:0] int_mask, next_int_mask;
  logic [7:0] rx_buf, next_rx_buf;
  logic rx_full, next_rx_full;
  logic [7:0] tx_hold, next_tx_hold;
  logic tx_pend, next_tx_pend;
  logic paused, next_paused;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  dsp_rx_t rx_st, next_rx_st;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  dsp_tx_t tx_st, next_tx_st;
  logic [9:0] tx_sh, next_tx_sh;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_bit, next_tx_bit;
  logic tx_line, next_tx_line;
  logic dtr, next_dtr;
  logic rts, next_rts;
  logic acc, hit, permit;
  logic [3:0] ev;
  logic [5:0] status;
  logic ring_prev, carrier_prev;
  always_comb begin
    acc = psel && penable && pready;
    status = {pin_q[4], pin_q[3], pin_q[2], pin_q[1], rx_full, tx_pend || (tx_st == DSP_TX_SEND)};
    hit = 1'b1;
    case (paddr)
      `DSP_REG_CTRL: next_prdata = {28'h0, ctrl};
      `DSP_REG_STATUS: next_prdata = {26'h0, status};
      `DSP_REG_TXDATA: next_prdata = {24'h0, tx_hold};
      `DSP_REG_RXDATA: next_prdata = {24'h0, rx_buf};
      `DSP_REG_DIV: next_prdata = {16'h0, div};
      `DSP_REG_INT_STAT: next_prdata = {28'h0, int_stat};
      `DSP_REG_INT_MASK: next_prdata = {28'h0, int_mask};
      default: begin
        next_prdata = 32'h0;
        hit = 1'b0;
      end
    endcase
    next_pready = psel && penable && !pready;
    next_pslverr = next_pready && !hit;
    next_ctrl = ctrl;
    next_div = div;
    next_int_mask = int_mask;
    next_tx_hold = tx_hold;
    next_tx_pend = tx_pend;
    next_rx_buf = rx_buf;
    next_rx_full = rx_full;
    next_paused = paused && ctrl[`DSP_CTRL_SW_FLOW];
    ev = 4'h0;
    if (acc && pwrite) begin
      case (paddr)
        `DSP_REG_CTRL: next_ctrl = pwdata[3:0];
        `DSP_REG_DIV: next_div = pwdata[15:0];
        `DSP_REG_INT_MASK: next_int_mask = pwdata[3:0];
        `DSP_REG_TXDATA: begin
          // A write while a character waits or is on the line is dropped; poll the busy bit
          if (!status[`DSP_ST_TX_BUSY]) begin
            next_tx_hold = pwdata[7:0];
            next_tx_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (acc && !pwrite && paddr == `DSP_REG_RXDATA) begin
      next_rx_full = 1'b0;
    end
    // Receiver
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt + 16'h0001;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    case (rx_st)
      DSP_RX_IDLE: begin
        next_rx_cnt = 16'h0000;
        next_rx_bit = 3'h0;
        if (!pin_q[0]) begin
          next_rx_st = DSP_RX_START;
        end
      end
      DSP_RX_START: begin
        if (rx_cnt == {1'b0, div[15:1]}) begin
          next_rx_cnt = 16'h0000;
          next_rx_st = pin_q[0] ? DSP_RX_IDLE : DSP_RX_DATA;
        end
      end
      DSP_RX_DATA: begin
        if (rx_cnt == div - 16'h0001) begin
          next_rx_cnt = 16'h0000;
          next_rx_sh = {pin_q[0], rx_sh[7:1]};
          next_rx_bit = rx_bit + 3'h1;
          if (rx_bit == 3'h7) begin
            next_rx_st = DSP_RX_STOP;
          end
        end
      end
      DSP_RX_STOP: begin
        if (rx_cnt == div - 16'h0001) begin
          next_rx_st = DSP_RX_IDLE;
          if (pin_q[0]) begin
            if (ctrl[`DSP_CTRL_SW_FLOW] && rx_sh == `DSP_XOFF) begin
              next_paused = 1'b1;
            end else if (ctrl[`DSP_CTRL_SW_FLOW] && rx_sh == `DSP_XON) begin
              next_paused = 1'b0;
            end else begin
              next_rx_buf = rx_sh;
              next_rx_full = 1'b1;
              ev[`DSP_INT_RX] = 1'b1;
            end
          end
        end
      end
      default: begin
        next_rx_st = DSP_RX_IDLE;
      end
    endcase
    // Transmitter
    permit = (!ctrl[`DSP_CTRL_HW_FLOW] || pin_q[1]) && (!ctrl[`DSP_CTRL_SW_FLOW] || !paused);
    next_tx_st = tx_st;
    next_tx_sh = tx_sh;
    next_tx_cnt = tx_cnt + 16'h0001;
    next_tx_bit = tx_bit;
    case (tx_st)
      DSP_TX_IDLE: begin
        next_tx_cnt = 16'h0000;
        next_tx_bit = 4'h0;
        if (tx_pend && permit) begin
          next_tx_sh = {1'b1, tx_hold, 1'b0};
          next_tx_pend = 1'b0;
          next_tx_st = DSP_TX_SEND;
        end
      end
      DSP_TX_SEND: begin
        if (tx_cnt == div - 16'h0001) begin
          next_tx_cnt = 16'h0000;
          next_tx_sh = {1'b1, tx_sh[9:1]};
          next_tx_bit = tx_bit + 4'h1;
          if (tx_bit == 4'h9) begin
            next_tx_st = DSP_TX_IDLE;
            ev[`DSP_INT_TX] = 1'b1;
          end
        end
      end
      default: begin
        next_tx_st = DSP_TX_IDLE;
      end
    endcase
    ev[`DSP_INT_RING] = pin_q[3] && !ring_prev;
    ev[`DSP_INT_CARRIER] = pin_q[2] != carrier_prev;
    // Set wins over the write-one clear
    next_int_stat = int_stat;
    if (acc && pwrite && paddr == `DSP_REG_INT_STAT) begin
      next_int_stat = int_stat & ~pwdata[3:0];
    end
    next_int_stat = next_int_stat | ev;
    next_dtr = ctrl[`DSP_CTRL_TERM_READY];
    // With hardware flow on, drop the request while the receive buffer is unread so the far end pauses
    next_rts = next_ctrl[`DSP_CTRL_SEND_REQ] && !(next_ctrl[`DSP_CTRL_HW_FLOW] && next_rx_full);
    if (!resetn) begin
      next_prdata = 32'h0;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_ctrl = 4'h0;
      next_div = `DSP_DIV_RESET;
      next_int_stat = 4'h0;
      next_int_mask = 4'h0;
      next_rx_buf = 8'h00;
      next_rx_full = 1'b0;
      next_tx_hold = 8'h00;
      next_tx_pend = 1'b0;
      next_paused = 1'b0;
      next_rx_st = DSP_RX_IDLE;
      next_rx_cnt = 16'h0000;
      next_rx_bit = 3'h0;
      next_rx_sh = 8'h00;
      next_tx_st = DSP_TX_IDLE;
      next_tx_sh = 10'h3ff;
      next_tx_cnt = 16'h0000;
      next_tx_bit = 4'h0;
      next_dtr = 1'b0;
      next_rts = 1'b0;
    end
    next_tx_line = (next_tx_st == DSP_TX_SEND) ? next_tx_sh[0] : 1'b1;
    next_irq = |(next_int_stat & next_int_mask);
  end
  always_ff @(posedge clk) begin
    prdata <= next_prdata;
    pready <= next_pready;
    pslverr <= next_pslverr;
    irq <= next_irq;
    ctrl <= next_ctrl;
    div <= next_div;
    int_stat <= next_int_stat;
    int_mask <= next_int_mask;
    rx_buf <= next_rx_buf;
    rx_full <= next_rx_full;
    tx_hold <= next_tx_hold;
    tx_pend <= next_tx_pend;
    paused <= next_paused;
    rx_st <= next_rx_st;
    rx_cnt <= next_rx_cnt;
    rx_bit <= next_rx_bit;
    rx_sh <= next_rx_sh;
    tx_st <= next_tx_st;
    tx_sh <= next_tx_sh;
    tx_cnt <= next_tx_cnt;
    tx_bit <= next_tx_bit;
    tx_line <= next_tx_line;
    dtr <= next_dtr;
    rts <= next_rts;
    ring_prev <= resetn && pin_q[3];
    carrier_prev <= resetn && pin_q[2];
  end
  assign lnk.serial_in_from_host = tx_line;
  assign lnk.terminal_ready_in = dtr;
  assign lnk.send_request_in = rts;
endmodule : dsp_dte

/* File: dsp_link_assertions.sv */
// Checker of the link that joins the two ends.
// Assumes a 44-cycle bit time set on both ends.
`timescale 1ns/1ps
module dsp_link_assertions
  import dsp_pkg::*;
(
  // Clock, reset, link lines and equipment-side causes
  input wire logic clk,
  input wire logic resetn,
  input wire logic serial_in_from_host,
  input wire logic serial_out_to_host,
  input wire logic carrier_detect_out,
  input wire logic set_ready_out,
  input wire logic send_clear_out,
  input wire logic ring_indicate_out,
  input wire logic carrier_on,
  input wire logic set_ready,
  input wire logic cfg_hw_flow,
  input wire logic rx_room,
  input wire dsp_alt_func_t cfg_alt_func
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Start plus eight zero bits is the longest space
  a_out_low_max: assert property ($fell(serial_out_to_host) |-> ##[1:396] serial_out_to_host)
    else $error("out low too long");
  a_in_low_max: assert property ($fell(serial_in_from_host) |-> ##[1:396] serial_in_from_host)
    else $error("in low too long");
  a_out_bit_hold: assert property ($changed(serial_out_to_host) |=> $stable(serial_out_to_host) [*8])
    else $error("out bit short");
  a_in_bit_hold: assert property ($changed(serial_in_from_host) |=> $stable(serial_in_from_host) [*8])
    else $error("in bit short");
  a_idle_at_release: assert property ($rose(resetn) |-> serial_out_to_host && !ring_indicate_out)
    else $error("bad idle level");
  a_carrier_follows: assert property ($past(resetn) |-> carrier_detect_out == $past(carrier_on))
    else $error("carrier wrong");
  a_clear_by_room: assert property (
    $past(resetn) |-> send_clear_out == (!$past(cfg_hw_flow) || $past(rx_room)))
    else $error("clear wrong");
  a_set_ready_alt: assert property (
    $past(resetn) |-> set_ready_out == ($past(set_ready) && $past(cfg_alt_func) == DSP_ALT_SET_READY))
    else $error("set ready wrong");
endmodule : dsp_link_assertions

/* File: tb_dce_serial_port_modem_ctrl.sv */
// Bench: both ends joined, APB on the terminal end.
// Assumes 44-cycle bits and a 50-cycle ready poll.
`timescale 1ns/1ps
`include "dsp_consts.svh"
module tb_dce_serial_port_modem_ctrl;
  import dsp_pkg::*;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr, irq;
  logic tx_valid = 0, rx_room = 1, cfg_hw_flow = 0, carrier_on = 0, set_ready = 0, call_ring = 0, unsolicited_result = 0, gpio = 0;
  logic tx_ready, rx_valid, ignite, terminal_ready, alt_pin;
  logic [7:0] paddr = 0, tx_data = 0, rx_data, expq[$];
  logic [15:0] div = 16'h002c;
  logic [31:0] pwdata = 0, prdata, rd, lfsr = 32'h28538ec7;
  dsp_alt_func_t cfg_alt_func = DSP_ALT_SET_READY;
  dsp_ring_mode_t cfg_ring_mode = DSP_RING_CALL;
  int miscompares = 0, checked = 0, ign = 0;
  dsp_link_if lnk();
  dsp_dce #(.DTR_POLL_CYCLES(50), .URC_PULSE_CYCLES(10)) dsp_dce_i (.clk, .resetn, .lnk(lnk.dce),
    .cfg_rate_div(div), .cfg_autobaud(1'b0), .cfg_hw_flow, .cfg_sw_flow(1'b0), .cfg_ring_mode, .cfg_alt_func,
    .tx_valid, .tx_data, .tx_ready, .rx_room, .rx_valid, .rx_data, .rx_frame_err(), .rate_locked(), .carrier_on,
    .set_ready, .call_ring, .urc_event(unsolicited_result), .gpio_out(gpio), .spi_clk_in(1'b0), .alt_pin_out(alt_pin),
    .terminal_ready, .ignite);
  dsp_dte dsp_dte_i (.clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .irq, .lnk(lnk.dte));
  dsp_link_assertions dsp_link_assertions_i (.clk, .resetn, .serial_in_from_host(lnk.serial_in_from_host),
    .serial_out_to_host(lnk.serial_out_to_host), .carrier_detect_out(lnk.carrier_detect_out),
    .set_ready_out(lnk.set_ready_out), .send_clear_out(lnk.send_clear_out),
    .ring_indicate_out(lnk.ring_indicate_out), .carrier_on, .set_ready, .cfg_hw_flow, .rx_room, .cfg_alt_func);
  always #12.5 clk = ~clk;
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic ap(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : ap
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    if (rx_valid === 1'b1) chk("rx_data", expq.pop_front(), rx_data);
    ign += (ignite === 1'b1);
  end
  initial begin
    #1000000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1;
    ap(0, `DSP_REG_DIV, 0);
    chk("div", {16'h0, `DSP_DIV_RESET}, rd);
    ap(1, `DSP_REG_DIV, 44);
    ap(0, 8'h1c, 0);
    chk("slverr", 1, err);
    carrier_on <= 1;
    set_ready <= 1;
    ap(1, `DSP_REG_INT_MASK, 4);
    repeat (10) @(posedge clk);
    chk("irq_masked", 0, irq);
    call_ring <= 1;
    repeat (10) @(posedge clk);
    chk("irq", 1, irq);
    ap(1, `DSP_REG_INT_STAT, 4);
    repeat (2) @(posedge clk);
    chk("irq_clr", 0, irq);
    cfg_alt_func <= DSP_ALT_GPIO;
    gpio <= 1;
    call_ring <= 0;
    cfg_ring_mode <= DSP_RING_CALL_URC;
    unsolicited_result <= 1;
    @(posedge clk);
    unsolicited_result <= 0;
    repeat (8) @(posedge clk);
    chk("urc_ring", 1, lnk.ring_indicate_out);
    chk("alt_pin", 1, alt_pin);
    repeat (8) @(posedge clk);
    chk("urc_end", 0, lnk.ring_indicate_out);
    cfg_hw_flow <= 1;
    rx_room <= 0;
    repeat (6) @(posedge clk);
    chk("clear", 0, lnk.send_clear_out);
    chk("tx_hold", 0, tx_ready);
    chk("no_ignite", 0, ign);
    cfg_hw_flow <= 0;
    rx_room <= 1;
    ap(1, `DSP_REG_CTRL, 4);
    repeat (4) begin
      lfsr = nx(lfsr);
      expq.push_back(lfsr[7:0]);
      ap(1, `DSP_REG_TXDATA, lfsr[7:0]);
      do ap(0, `DSP_REG_STATUS, 0); while (rd[0] !== 1'b0);
    end
    chk("ignite", 1, ign);
    chk("ready", 1, terminal_ready);
    lfsr = nx(lfsr);
    tx_data <= lfsr[7:0];
    tx_valid <= 1;
    do @(posedge clk); while (tx_ready !== 1'b1);
    tx_valid <= 0;
    @(negedge lnk.serial_out_to_host);
    for (int k = 0; k < 10; k++) begin
      repeat (k ? 44 : 22) @(posedge clk);
      chk("wire", {1'b1, lfsr[7:0], 1'b0} >> k & 1, lnk.serial_out_to_host);
    end
    do ap(0, `DSP_REG_STATUS, 0); while (rd[1] !== 1'b1);
    ap(0, `DSP_REG_RXDATA, 0);
    chk("rxdata", lfsr[7:0], rd);
    chk("pending", 0, expq.size());
    finish_test;
  end
endmodule : tb_dce_serial_port_modem_ctrl
